// ### touch_panel_pkg.sv
// constants and carrier types for the touch button event logic
package touch_panel_pkg;

	localparam int N_BTN  = 4;
	localparam int N_SNS  = 2;
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

	// press classes and indicator timing, in ms
	localparam logic [12:0] TAP_LIMIT_MS   = 13'd500;
	localparam logic [12:0] LONG_START_MS  = 13'd2000;
	localparam logic [12:0] LONG_END_MS    = 13'd5000;
	localparam logic [12:0] PRESS_SAT_MS   = 13'h1FFF;
	localparam logic [10:0] BLINK_TOTAL_MS = 11'd2000;
	localparam logic [7:0]  BLINK_HALF_MS  = 8'd250;

	// sensor spans in tenths of a unit
	localparam logic [15:0] TEMP_MAX_TENTHS  = 16'd450;
	localparam logic [15:0] LIGHT_MAX_TENTHS = 16'd1000;

	// register byte offsets
	localparam logic [7:0] BTN_MODE_BASE  = 8'h00;
	localparam logic [7:0] BTN_HOLD_BASE  = 8'h10;
	localparam logic [7:0] BTN_IMAGE_BASE = 8'h20;
	localparam logic [7:0] CMD_OFS        = 8'h30;
	localparam logic [7:0] STATUS_OFS     = 8'h34;
	localparam logic [7:0] SNS_BASE       = 8'h40;
	localparam logic [7:0] SNS_STRIDE     = 8'h20;
	localparam logic [7:0] SNS_HYST_OFS   = 8'h00;
	localparam logic [7:0] SNS_AVG_OFS    = 8'h04;
	localparam logic [7:0] SNS_LOW_OFS    = 8'h08;
	localparam logic [7:0] SNS_HIGH_OFS   = 8'h0C;
	localparam logic [7:0] SNS_VALUE_OFS  = 8'h10;

	// image register field positions
	localparam int IMG_OFF_LSB = 0;
	localparam int IMG_OFF_SET = 8;
	localparam int IMG_OFF_INV = 9;
	localparam int IMG_ON_LSB  = 16;
	localparam int IMG_ON_INV  = 24;
	// command register field positions
	localparam int CMD_BTN_LSB  = 0;
	localparam int CMD_CODE_LSB = 2;

	// reset values and averaging shift limit
	localparam logic [15:0] HOLD_START_RST  = 16'd1000;
	localparam logic [15:0] HOLD_PERIOD_RST = 16'd500;
	localparam logic [15:0] HYST_RST        = 16'd5;
	localparam logic [3:0]  AVG_SHIFT_RST   = 4'h0;
	localparam logic [3:0]  AVG_SHIFT_MAX   = 4'hA;

	typedef enum logic [1:0] {
		MODE_MONO = 2'h0,
		MODE_BIST = 2'h1,
		MODE_LOCK = 2'h2
	} btn_mode_e;

	typedef enum logic [2:0] {
		CMD_NONE      = 3'h0,
		CMD_OK_BLINK  = 3'h1,
		CMD_ERR_BLINK = 3'h2,
		CMD_GREEN_ON  = 3'h3,
		CMD_GREEN_OFF = 3'h4
	} cmd_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	typedef struct packed {
		logic state_change_evt;
		logic rise_evt;
		logic fall_evt;
		logic tap_evt;
		logic short_press_evt;
		logic long_press_evt;
		logic hold_repeat_evt;
	} btn_evt_s;

	typedef struct packed {
		logic       show_image;
		logic       invert;
		logic [7:0] image_id;
	} disp_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] value;
	} sample_s;

	typedef struct packed {
		logic state_change_evt;
		logic rising_cross_evt;
		logic falling_cross_evt;
		logic range_exit_evt;
	} sns_evt_s;

endpackage

// ### touch_button_event_logic.sv
// four touch buttons and two sensors: events, indicators, image choice
// Function
// - mode 0 mono, 1 bistable, 2 locked red
// - mode write command adopts written mode
// - hold event after start, then every period
// - button value is one bit
// - off image wins over text label
// - off image unless bistable and value 1
// - tilde flag renders image inverted
// - ok command blinks green 2 s, 500 ms
// - error command blinks red 2 s, 500 ms
// - green lamp steady on/off commands
// - change event on any value change
// - rise on high, fall on low
// - tap event under 500 ms
// - short press 500 to 2000 ms
// - long press 2000 to 5000 ms
// - sensor hysteresis in tenths
// - sensor samples averaged over ms window
// - range exit below low or above high
// - temperature 0-45 C, light 0-100 %
// - rising/falling cross at hysteresis thresholds
// - sensor change event beyond hysteresis
`timescale 1ns/1ps

module touch_button_event_logic
	import touch_panel_pkg::*;
#(
	parameter int MS_DIV = MS_CYCLES
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic [N_BTN-1:0]            btn_pin,
	input  wire sample_s [N_SNS-1:0]         sns_sample,
	input  wire bus_req_s                    bus,
	output logic [31:0]                      rdata,
	output btn_evt_s [N_BTN-1:0]             btn_evt,
	output sns_evt_s [N_SNS-1:0]             sns_evt,
	output logic [N_BTN-1:0]                 btn_value,
	output logic [N_BTN-1:0]                 green_led,
	output logic [N_BTN-1:0]                 red_led,
	output disp_s [N_BTN-1:0]                disp
);

	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic        pressed;
		btn_mode_e   mode;
		logic        value;
		logic [12:0] press_ms;
		logic [15:0] hold_cnt;
		logic        hold_first;
		logic [15:0] hold_start_time;
		logic [15:0] hold_repeat_period;
		logic [7:0]  off_image_name;
		logic [7:0]  on_image_name;
		logic        off_set;
		logic        off_inv;
		logic        on_inv;
		logic        green_on;
		logic [10:0] blink_ms;
		logic [7:0]  blink_ph;
		logic        blink_lit;
		logic        blink_g;
		logic        blink_r;
		btn_evt_s    evt;
	} btn_st_s;

	typedef struct packed {
		logic [15:0] hyst;
		logic [3:0]  avg_shift;
		logic [15:0] range_low_limit;
		logic [15:0] range_high_limit;
		logic [15:0] latest;
		logic [31:0] sum;
		logic [15:0] win_ms;
		logic [15:0] value;
		logic [15:0] ref_val;
		logic        out_range;
		sns_evt_s    evt;
	} sns_st_s;

	typedef struct packed {
		logic [15:0]             ms_div;
		logic                    ms_tick;
		btn_st_s [N_BTN-1:0]     btn;
		sns_st_s [N_SNS-1:0]     sns;
		logic [31:0]             rdata;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	function automatic state_s reset_state();
		state_s r;
		r = '0;
		for (int i = 0; i < N_BTN; i++) begin
			r.btn[i].mode = MODE_MONO;
			r.btn[i].hold_start_time = HOLD_START_RST;
			r.btn[i].hold_repeat_period = HOLD_PERIOD_RST;
		end
		for (int j = 0; j < N_SNS; j++) begin
			r.sns[j].hyst = HYST_RST;
			r.sns[j].avg_shift = AVG_SHIFT_RST;
			r.sns[j].range_high_limit = 16'hFFFF;
		end
		return r;
	endfunction

	always_comb begin
		btn_st_s     b;
		sns_st_s     t;
		logic        rise_p;
		logic        fall_p;
		logic [15:0] target;
		logic [15:0] hcnt;
		logic [15:0] win_len;
		logic [31:0] acc;
		logic [15:0] avg;
		logic [15:0] span;
		logic [16:0] up_thr;
		logic [16:0] val_h;
		logic        oor;
		logic [7:0]  ofs;
		logic [31:0] rd_mux;
		logic [1:0]  cmd_btn;
		logic [2:0]  cmd_code;
		b = '0;
		t = '0;
		rise_p = 1'b0;
		fall_p = 1'b0;
		target = '0;
		hcnt = '0;
		win_len = '0;
		acc = '0;
		avg = '0;
		span = '0;
		up_thr = '0;
		val_h = '0;
		oor = 1'b0;
		ofs = '0;
		rd_mux = '0;
		cmd_btn = bus.wdata[CMD_BTN_LSB +: 2];
		cmd_code = bus.wdata[CMD_CODE_LSB +: 3];
		s_nxt = s_r;

		// 1 ms time base
		s_nxt.ms_tick = 1'b0;
		if (s_r.ms_div == 16'(MS_DIV - 1)) begin
			s_nxt.ms_div = '0;
			s_nxt.ms_tick = 1'b1;
		end else begin
			s_nxt.ms_div = s_r.ms_div + 16'h0001;
		end

		for (int i = 0; i < N_BTN; i++) begin
			b = s_r.btn[i];
			b.evt = '0;
			b.sync1 = btn_pin[i];
			b.sync2 = s_r.btn[i].sync1;
			b.pressed = s_r.btn[i].sync2;
			rise_p = s_r.btn[i].sync2 & ~s_r.btn[i].pressed;
			fall_p = ~s_r.btn[i].sync2 & s_r.btn[i].pressed;

			// press duration and classification on release
			if (rise_p) begin
				b.press_ms = '0;
			end else if (s_r.btn[i].pressed && s_r.ms_tick &&
				s_r.btn[i].press_ms != PRESS_SAT_MS) begin
				b.press_ms = s_r.btn[i].press_ms + 13'h0001;
			end
			if (fall_p) begin
				if (s_r.btn[i].press_ms < TAP_LIMIT_MS)
					b.evt.tap_evt = 1'b1;
				else if (s_r.btn[i].press_ms < LONG_START_MS)
					b.evt.short_press_evt = 1'b1;
				else if (s_r.btn[i].press_ms <= LONG_END_MS)
					b.evt.long_press_evt = 1'b1;
			end

			// repeating hold events
			target = s_r.btn[i].hold_first ? s_r.btn[i].hold_start_time :
				s_r.btn[i].hold_repeat_period;
			hcnt = s_r.btn[i].hold_cnt + 16'h0001;
			if (rise_p) begin
				b.hold_cnt = '0;
				b.hold_first = 1'b1;
			end else if (s_r.btn[i].pressed && s_r.ms_tick) begin
				if (target != '0 && hcnt >= target) begin
					b.evt.hold_repeat_evt = 1'b1;
					b.hold_cnt = '0;
					b.hold_first = 1'b0;
				end else begin
					b.hold_cnt = hcnt;
				end
			end

			// value per mode
			unique case (s_r.btn[i].mode)
				MODE_BIST: begin
					if (fall_p)
						b.value = ~s_r.btn[i].value;
				end
				MODE_LOCK: begin
					b.value = s_r.btn[i].value;
				end
				default: begin
					b.value = s_r.btn[i].sync2;
				end
			endcase
			if (b.value != s_r.btn[i].value) begin
				b.evt.state_change_evt = 1'b1;
				b.evt.rise_evt = b.value;
				b.evt.fall_evt = ~b.value;
			end

			// blink timing, 250 ms lit then 250 ms dark
			if (s_r.ms_tick && s_r.btn[i].blink_ms != '0) begin
				b.blink_ms = s_r.btn[i].blink_ms - 11'h001;
				if (s_r.btn[i].blink_ph == BLINK_HALF_MS - 8'h01) begin
					b.blink_ph = '0;
					b.blink_lit = ~s_r.btn[i].blink_lit;
				end else begin
					b.blink_ph = s_r.btn[i].blink_ph + 8'h01;
				end
				if (b.blink_ms == '0) begin
					b.blink_g = 1'b0;
					b.blink_r = 1'b0;
				end
			end

			// command port
			if (bus.wr && bus.addr == CMD_OFS && cmd_btn == 2'(i)) begin
				unique case (cmd_code)
					CMD_OK_BLINK, CMD_ERR_BLINK: begin
						b.blink_ms = BLINK_TOTAL_MS;
						b.blink_ph = '0;
						b.blink_lit = 1'b1;
						b.blink_g = (cmd_code == CMD_OK_BLINK);
						b.blink_r = (cmd_code == CMD_ERR_BLINK);
					end
					CMD_GREEN_ON:  b.green_on = 1'b1;
					CMD_GREEN_OFF: b.green_on = 1'b0;
					default: ;
				endcase
			end
			if (bus.wr && bus.addr == BTN_MODE_BASE + 8'(4 * i))
				b.mode = btn_mode_e'(bus.wdata[1:0]);
			if (bus.wr && bus.addr == BTN_HOLD_BASE + 8'(4 * i)) begin
				b.hold_start_time = bus.wdata[15:0];
				b.hold_repeat_period = bus.wdata[31:16];
			end
			if (bus.wr && bus.addr == BTN_IMAGE_BASE + 8'(4 * i)) begin
				b.off_image_name = bus.wdata[IMG_OFF_LSB +: 8];
				b.off_set = bus.wdata[IMG_OFF_SET];
				b.off_inv = bus.wdata[IMG_OFF_INV];
				b.on_image_name = bus.wdata[IMG_ON_LSB +: 8];
				b.on_inv = bus.wdata[IMG_ON_INV];
			end
			s_nxt.btn[i] = b;
		end

		for (int j = 0; j < N_SNS; j++) begin
			t = s_r.sns[j];
			t.evt = '0;
			span = (j == 0) ? TEMP_MAX_TENTHS : LIGHT_MAX_TENTHS;
			if (sns_sample[j].valid)
				t.latest = sns_sample[j].value;
			win_len = 16'h0001 << s_r.sns[j].avg_shift;
			acc = s_r.sns[j].sum + {16'h0000, s_r.sns[j].latest};
			if (s_r.ms_tick) begin
				if (s_r.sns[j].win_ms + 16'h0001 == win_len) begin
					avg = 16'(acc >> s_r.sns[j].avg_shift);
					if (avg > span)
						avg = span;
					t.value = avg;
					t.sum = '0;
					t.win_ms = '0;
					up_thr = {1'b0, s_r.sns[j].ref_val} +
						{1'b0, s_r.sns[j].hyst};
					val_h = {1'b0, avg} + {1'b0, s_r.sns[j].hyst};
					if ({1'b0, avg} > up_thr) begin
						t.evt.rising_cross_evt = 1'b1;
						t.evt.state_change_evt = 1'b1;
						t.ref_val = avg;
					end else if (val_h < {1'b0, s_r.sns[j].ref_val}) begin
						t.evt.falling_cross_evt = 1'b1;
						t.evt.state_change_evt = 1'b1;
						t.ref_val = avg;
					end
					oor = (avg < s_r.sns[j].range_low_limit) ||
						(avg > s_r.sns[j].range_high_limit);
					t.out_range = oor;
					t.evt.range_exit_evt = oor & ~s_r.sns[j].out_range;
				end else begin
					t.sum = acc;
					t.win_ms = s_r.sns[j].win_ms + 16'h0001;
				end
			end
			ofs = SNS_BASE + 8'(j) * SNS_STRIDE;
			if (bus.wr && bus.addr == ofs + SNS_HYST_OFS)
				t.hyst = bus.wdata[15:0];
			if (bus.wr && bus.addr == ofs + SNS_AVG_OFS) begin
				t.avg_shift = (bus.wdata[3:0] > AVG_SHIFT_MAX) ?
					AVG_SHIFT_MAX : bus.wdata[3:0];
				t.sum = '0;
				t.win_ms = '0;
			end
			if (bus.wr && bus.addr == ofs + SNS_LOW_OFS)
				t.range_low_limit = bus.wdata[15:0];
			if (bus.wr && bus.addr == ofs + SNS_HIGH_OFS)
				t.range_high_limit = bus.wdata[15:0];
			s_nxt.sns[j] = t;
		end

		// read mux, data valid only in the cycle after the strobe
		for (int i = 0; i < N_BTN; i++) begin
			if (bus.addr == BTN_MODE_BASE + 8'(4 * i))
				rd_mux = {30'h0, s_r.btn[i].mode};
			if (bus.addr == BTN_HOLD_BASE + 8'(4 * i))
				rd_mux = {s_r.btn[i].hold_repeat_period,
					s_r.btn[i].hold_start_time};
			if (bus.addr == BTN_IMAGE_BASE + 8'(4 * i))
				rd_mux = {7'h00, s_r.btn[i].on_inv,
					s_r.btn[i].on_image_name, 6'h00,
					s_r.btn[i].off_inv, s_r.btn[i].off_set,
					s_r.btn[i].off_image_name};
		end
		if (bus.addr == STATUS_OFS)
			rd_mux = {20'h0, red_led, green_led, btn_value};
		for (int j = 0; j < N_SNS; j++) begin
			ofs = SNS_BASE + 8'(j) * SNS_STRIDE;
			if (bus.addr == ofs + SNS_HYST_OFS)
				rd_mux = {16'h0, s_r.sns[j].hyst};
			if (bus.addr == ofs + SNS_AVG_OFS)
				rd_mux = {28'h0, s_r.sns[j].avg_shift};
			if (bus.addr == ofs + SNS_LOW_OFS)
				rd_mux = {16'h0, s_r.sns[j].range_low_limit};
			if (bus.addr == ofs + SNS_HIGH_OFS)
				rd_mux = {16'h0, s_r.sns[j].range_high_limit};
			if (bus.addr == ofs + SNS_VALUE_OFS)
				rd_mux = {16'h0, s_r.sns[j].value};
		end
		s_nxt.rdata = bus.rd ? rd_mux : 32'h0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			s_r <= reset_state();
		else
			s_r <= s_nxt;
	end

	// outputs from state
	always_comb begin
		for (int i = 0; i < N_BTN; i++) begin
			btn_evt[i] = s_r.btn[i].evt;
			btn_value[i] = s_r.btn[i].value;
			green_led[i] = s_r.btn[i].blink_g ? s_r.btn[i].blink_lit :
				s_r.btn[i].green_on;
			red_led[i] = (s_r.btn[i].mode == MODE_LOCK) ||
				(s_r.btn[i].blink_r & s_r.btn[i].blink_lit);
			disp[i].show_image = s_r.btn[i].off_set;
			if (s_r.btn[i].mode == MODE_BIST && s_r.btn[i].value) begin
				disp[i].image_id = s_r.btn[i].on_image_name;
				disp[i].invert = s_r.btn[i].on_inv;
			end else begin
				disp[i].image_id = s_r.btn[i].off_image_name;
				disp[i].invert = s_r.btn[i].off_inv;
			end
		end
		for (int j = 0; j < N_SNS; j++)
			sns_evt[j] = s_r.sns[j].evt;
		rdata = s_r.rdata;
	end

endmodule

// ### tbel_props.sv
// port assertions for the touch button event logic
`timescale 1ns/1ps
module tbel_props
	import touch_panel_pkg::*;
(
	input	wire logic			clk,
	input	wire logic			rst,
	input	wire logic [N_BTN-1:0]	btn_pin,
	input	wire bus_req_s		bus,
	input	wire logic [31:0]		rdata,
	input	wire btn_evt_s [N_BTN-1:0]	btn_evt,
	input	wire sns_evt_s [N_SNS-1:0]	sns_evt,
	input	wire logic [N_BTN-1:0]	btn_value,
	input	wire logic [N_BTN-1:0]	red_led
);
	logic [1:0]	mode0_r;
	btn_evt_s	e0;
	sns_evt_s	s0;
	assign e0 = btn_evt[0];
	assign s0 = sns_evt[0];
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			mode0_r <= 2'h0;
		else if (bus.wr && bus.addr == BTN_MODE_BASE)
			mode0_r <= bus.wdata[1:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_rdata_idle: assert property (!bus.rd |=> rdata == 32'h0)
		else $error("read data not idle");
	chk_lock_red: assert property (
		mode0_r == 2'h2 && $stable(mode0_r) |-> red_led[0])
		else $error("red lamp dark in locked mode");
	chk_rise_evt: assert property (
		$rose(btn_pin[0]) && mode0_r == 2'h0 |-> ##[3:5] e0.rise_evt)
		else $error("rise event missing");
	chk_fall_evt: assert property (
		$fell(btn_pin[0]) && mode0_r == 2'h0 |-> ##[3:5] e0.fall_evt)
		else $error("fall event missing");
	chk_change_edge: assert property (
		e0.rise_evt || e0.fall_evt |-> e0.state_change_evt)
		else $error("change event missing");
	chk_mono_follow: assert property (
		e0.rise_evt && mode0_r == 2'h0 |-> btn_value[0])
		else $error("value not following press");
	chk_lock_frozen: assert property (
		mode0_r == 2'h2 && $stable(mode0_r) |=> $stable(btn_value[0]))
		else $error("value moved in locked mode");
	chk_class_one: assert property (
		e0.tap_evt || e0.short_press_evt || e0.long_press_evt |->
		$onehot0({e0.tap_evt, e0.short_press_evt, e0.long_press_evt}) &&
		!$past(btn_pin[0], 3))
		else $error("press class not at a single release");
	chk_change_value: assert property (
		$changed(btn_value[0]) |->
		e0.state_change_evt && e0.rise_evt == btn_value[0])
		else $error("value moved without change event");
	chk_sns_change: assert property (
		s0.rising_cross_evt || s0.falling_cross_evt |-> s0.state_change_evt)
		else $error("sensor change event missing");
endmodule

// ### panel_ctrl_model.sv
// controller model: register bus master and event counters
`timescale 1ns/1ps
module panel_ctrl_model
	import touch_panel_pkg::*;
(
	input	wire logic			clk,
	input	wire logic [31:0]		rdata,
	input	wire btn_evt_s [N_BTN-1:0]	btn_evt,
	input	wire sns_evt_s [N_SNS-1:0]	sns_evt,
	output	bus_req_s			bus
);
	int	ev_n[N_BTN][7];
	int	se_n[N_SNS][4];
	initial bus = '0;
	always @(posedge clk) begin
		for (int i = 0; i < N_BTN; i++)
			for (int k = 0; k < 7; k++)
				if (btn_evt[i][k] === 1'b1) ev_n[i][k]++;
		for (int i = 0; i < N_SNS; i++)
			for (int k = 0; k < 4; k++)
				if (sns_evt[i][k] === 1'b1) se_n[i][k]++;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		// return on an edge, after the write has landed
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		// data stands in the cycle after the strobe, taken at its end
		@(posedge clk);
		d = rdata;
	endtask
endmodule

// ### touch_button_event_logic_tb.sv
// self-checking bench for the touch button event logic
`timescale 1ns/1ps
module touch_button_event_logic_tb;
	import touch_panel_pkg::*;
	localparam int MSD = 10;
	logic			clk;
	logic			rst;
	logic [N_BTN-1:0]	btn_pin;
	sample_s [N_SNS-1:0]	sns_sample;
	bus_req_s		bus;
	logic [31:0]		rdata;
	btn_evt_s [N_BTN-1:0]	btn_evt;
	sns_evt_s [N_SNS-1:0]	sns_evt;
	logic [N_BTN-1:0]	btn_value;
	logic [N_BTN-1:0]	green_led;
	logic [N_BTN-1:0]	red_led;
	disp_s [N_BTN-1:0]	disp;
	int			err_count;
	int			samples_checked;
	int			b;
	int			y;
	int			dl[3] = '{200, 650, 2450};
	logic [31:0]		d;
	logic [31:0]		img;

	touch_button_event_logic #(.MS_DIV(MSD)) u_touch_button_event_logic (
		.clk(clk), .rst(rst), .btn_pin(btn_pin), .sns_sample(sns_sample),
		.bus(bus), .rdata(rdata), .btn_evt(btn_evt), .sns_evt(sns_evt),
		.btn_value(btn_value), .green_led(green_led), .red_led(red_led),
		.disp(disp));
	panel_ctrl_model u_panel_ctrl_model (.clk(clk), .rdata(rdata),
		.btn_evt(btn_evt), .sns_evt(sns_evt), .bus(bus));

	task automatic chk(input string n, input logic [31:0] s, x);
		samples_checked++;
		if (s !== x) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic ms(input int n);
		repeat (n * MSD) @(posedge clk);
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] v);
		u_panel_ctrl_model.wr(a, v);
	endtask
	task automatic cmd(input cmd_e c, input int bt);
		w(CMD_OFS, 32'({c, 2'(bt)}));
	endtask
	task automatic press(input int bt, dur, v1, v2, ed);
		int c[7];
		for (int k = 0; k < 7; k++) c[k] = u_panel_ctrl_model.ev_n[bt][k];
		btn_pin[bt] <= 1'b1;
		ms(dur);
		chk("value held", btn_value[bt], v1);
		btn_pin[bt] <= 1'b0;
		ms(5);
		chk("value after", btn_value[bt], v2);
		for (int k = 0; k < 7; k++) c[k] = u_panel_ctrl_model.ev_n[bt][k] - c[k];
		chk("hold", c[0], dur < 300 ? 0 : 1 + (dur - 300) / 200);
		chk("tap", c[3], dur < 500);
		chk("short", c[2], dur >= 500 && dur < 2000);
		chk("long", c[1], dur >= 2000 && dur <= 5000);
		if (ed) begin
			chk("change", c[6], 2);
			chk("rise", c[5], 1);
			chk("fall", c[4], 1);
		end
		$display("press of %0d ms on button %0d done", dur, bt);
	endtask
	task automatic sns(input int s, v, r, f, x);
		int c[4];
		for (int k = 0; k < 4; k++) c[k] = u_panel_ctrl_model.se_n[s][k];
		sns_sample[s] <= '{1'b1, 16'(v)};
		ms(6);
		for (int k = 0; k < 4; k++) c[k] = u_panel_ctrl_model.se_n[s][k] - c[k];
		chk("cross up", c[2] > 0, r);
		chk("cross down", c[1] > 0, f);
		chk("sensor change", c[3] > 0, r | f);
		chk("range exit", c[0], x);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		stop_test;
	end
	initial begin
		rst = 1'b1;
		btn_pin = '0;
		sns_sample = '0;
		err_count = 0;
		samples_checked = 0;
		d = $urandom(32'h084c1ae5);
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		u_panel_ctrl_model.rd(BTN_HOLD_BASE, d);
		chk("hold reset", d, {HOLD_PERIOD_RST, HOLD_START_RST});
		u_panel_ctrl_model.rd(8'hFC, d);
		chk("unmapped", d, 32'h0);
		w(BTN_HOLD_BASE, {16'd200, 16'd300});
		foreach (dl[i]) press(0, dl[i], 1, 0, 1);
		w(BTN_MODE_BASE, 32'(MODE_LOCK));
		u_panel_ctrl_model.rd(BTN_MODE_BASE, d);
		chk("mode", d, 32'h2);
		chk("red lock", red_led[0], 1'b1);
		press(0, 100, 0, 0, 0);
		w(BTN_MODE_BASE, 32'(MODE_MONO));
		b = $urandom % N_BTN;
		y = (b + 1) % N_BTN;
		img = $urandom & 32'h01FF_02FF | 32'h100;
		w(BTN_MODE_BASE + 8'(4 * b), 32'(MODE_BIST));
		w(BTN_IMAGE_BASE + 8'(4 * b), img);
		chk("off image", disp[b], {1'b1, img[9], img[7:0]});
		press(b, 100, 0, 1, 0);
		chk("on image", disp[b][8:0], {img[24], img[23:16]});
		press(b, 100, 1, 0, 0);
		w(BTN_IMAGE_BASE + 8'(4 * b), img & ~32'h100);
		chk("label", disp[b].show_image, 1'b0);
		cmd(CMD_GREEN_ON, y);
		chk("green on", green_led[y], 1'b1);
		u_panel_ctrl_model.rd(STATUS_OFS, d);
		chk("status", d, 32'h10 << y);
		cmd(CMD_GREEN_OFF, y);
		chk("green off", green_led[y], 1'b0);
		cmd(CMD_OK_BLINK, b);
		cmd(CMD_ERR_BLINK, y);
		ms(100);
		chk("ok lit", green_led[b], 1'b1);
		chk("err lit", red_led[y], 1'b1);
		ms(250);
		chk("ok dark", green_led[b], 1'b0);
		chk("err dark", red_led[y], 1'b0);
		ms(1250);
		chk("ok late", green_led[b], 1'b1);
		chk("err late", red_led[y], 1'b1);
		ms(550);
		chk("ok end", green_led[b], 1'b0);
		chk("err end", red_led[y], 1'b0);
		$display("indicator test done");
		w(SNS_BASE + SNS_HIGH_OFS, 32'd200);
		sns(0, 100, 1, 0, 0);
		sns(0, 103, 0, 0, 0);
		sns(0, 600, 1, 0, 1);
		u_panel_ctrl_model.rd(SNS_BASE + SNS_VALUE_OFS, d);
		chk("temp clamp", d, 32'(TEMP_MAX_TENTHS));
		w(SNS_BASE + SNS_LOW_OFS, 32'd40);
		sns(0, 50, 0, 1, 0);
		sns(0, 20, 0, 1, 1);
		w(SNS_BASE + SNS_HYST_OFS, 32'd100);
		sns(0, 100, 0, 0, 0);
		sns(1, 2000, 1, 0, 0);
		u_panel_ctrl_model.rd(SNS_BASE + SNS_STRIDE + SNS_VALUE_OFS, d);
		chk("light clamp", d, 32'(LIGHT_MAX_TENTHS));
		// 4 ms window over a 4-step cyclic ramp: any window averages 250
		w(SNS_BASE + SNS_STRIDE + SNS_AVG_OFS, 32'h2);
		fork
			for (int k = 0; k < 32; k++) begin
				sns_sample[1] <= '{1'b1, 16'(100 * (k % 4 + 1))};
				ms(1);
			end
			begin
				ms(20);
				u_panel_ctrl_model.rd(SNS_BASE + SNS_STRIDE + SNS_VALUE_OFS, d);
			end
		join
		chk("light average", d, 32'd250);
		$display("sensor test done");
		stop_test;
	end
endmodule

bind touch_button_event_logic tbel_props u_tbel_props (.clk(clk),
	.rst(rst), .btn_pin(btn_pin), .bus(bus), .rdata(rdata),
	.btn_evt(btn_evt), .sns_evt(sns_evt), .btn_value(btn_value),
	.red_led(red_led));
